// ### design/ppsl_defs.svh
`ifndef PPSL_DEFS_SVH
`define PPSL_DEFS_SVH
// configuration address phase encoding
`define PPSL_CFG_TYPE0        2'b00
`define PPSL_CFG_TYPE1        2'b01
// general control register lock enable bit
`define PPSL_GCTL_OFFSET      8'hd4
`define PPSL_GCTL_LOCK_BIT    12
// message codes, low two bits of the interrupt codes carry the interrupt line
`define PPSL_MSG_ASSERT_INTX  8'h20
`define PPSL_MSG_DEASSERT_INTX 8'h24
`define PPSL_MSG_PM_PME       8'h18
// message header first dword: fmt 01, type 10100 (local) / 10000 (to root)
`define PPSL_HDR0_INTX        8'h34
`define PPSL_HDR0_PME         8'h30
`define PPSL_PME_TAG          8'h00
// power event resend interval
`define PPSL_PME_RESEND_US    100
`define PPSL_CLK_MHZ          125
`define PPSL_PME_RESEND_CYC   (`PPSL_PME_RESEND_US * `PPSL_CLK_MHZ)
`endif

// ### design/ppsl_pkg.sv
package ppsl_pkg;
	typedef enum logic [1:0] {PPSL_MSG_NONE, PPSL_MSG_INTX, PPSL_MSG_PME} ppsl_msg_kind_t;
	typedef enum {PPSL_LK_IDLE, PPSL_LK_REQ, PPSL_LK_BACKOFF, PPSL_LK_READ, PPSL_LK_LOCKED,
		PPSL_LK_WRITE, PPSL_LK_DRAIN} ppsl_lock_state_t;
endpackage

// ### design/ppsl_cfg_addr.sv
`timescale 1ns/10ps
`include "ppsl_defs.svh"
// builds the configuration address phase word
module ppsl_cfg_addr
	import ppsl_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        load_i,
	input  wire logic        type1_i,
	input  wire logic [7:0]  bus_i,
	input  wire logic [4:0]  dev_i,
	input  wire logic [2:0]  func_i,
	input  wire logic [5:0]  reg_i,
	output logic      [31:0] addr_o
);
	// one-hot select on the upper sixteen lines, none for 1xxxx
	function automatic logic [15:0] dev_select(input logic [4:0] dev);
		dev_select = dev[4] ? 16'h0000 : (16'h0001 << dev[3:0]);
	endfunction

	wire logic [31:0] type0_word;
	wire logic [31:0] type1_word;
	assign type0_word = {dev_select(dev_i), 5'h00, func_i, reg_i, `PPSL_CFG_TYPE0};
	assign type1_word = {8'h00, bus_i, dev_i, func_i, reg_i, `PPSL_CFG_TYPE1};

	// register the selected word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_o <= 32'h0000_0000;
		end else if (load_i) begin
			addr_o <= type1_i ? type1_word : type0_word;
		end
	end

	a_type1_layout: assert property (@(posedge clk_i) disable iff (rst_i)
		load_i && type1_i |=> addr_o[1:0] == 2'b01 && addr_o[23:16] == $past(bus_i))
		else $error("type 1 address layout wrong");
	a_dev15_bit31: assert property (@(posedge clk_i) disable iff (rst_i)
		load_i && !type1_i && dev_i == 5'h0f |=> addr_o[31:16] == 16'h8000)
		else $error("device 15 select wrong");
	a_high_dev_none: assert property (@(posedge clk_i) disable iff (rst_i)
		load_i && !type1_i && dev_i[4] |=> addr_o[31:16] == 16'h0000)
		else $error("select asserted for high device");
endmodule

// ### design/ppsl_msg_gen.sv
`timescale 1ns/10ps
`include "ppsl_defs.svh"
// builds the first two header dwords of an upstream message
module ppsl_msg_gen
	import ppsl_pkg::*;
(
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	input  wire logic           load_i,
	input  wire ppsl_msg_kind_t kind_i,
	input  wire logic           deassert_i,
	input  wire logic [1:0]     line_i,
	input  wire logic [7:0]     sec_bus_i,
	output logic      [31:0]    hdr0_o,
	output logic      [31:0]    hdr1_o
);
	wire logic [7:0] intx_code;
	wire logic [7:0] code;
	wire logic [7:0] hdr0_byte;
	assign intx_code = (deassert_i ? `PPSL_MSG_DEASSERT_INTX : `PPSL_MSG_ASSERT_INTX) | {6'h00, line_i};
	assign code      = (kind_i == PPSL_MSG_PME) ? `PPSL_MSG_PM_PME : intx_code;
	assign hdr0_byte = (kind_i == PPSL_MSG_PME) ? `PPSL_HDR0_PME : `PPSL_HDR0_INTX;

	// header registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hdr0_o <= 32'h0000_0000;
			hdr1_o <= 32'h0000_0000;
		end else if (load_i) begin
			hdr0_o <= {hdr0_byte, 24'h000000};
			hdr1_o <= {sec_bus_i, 5'h00, 3'h0, `PPSL_PME_TAG, code};
		end
	end

	a_pme_tag_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		load_i && kind_i == PPSL_MSG_PME |=> hdr1_o[15:8] == 8'h00 && hdr1_o[23:16] == 8'h00)
		else $error("power event tag or device not zero");
	a_intx_line: assert property (@(posedge clk_i) disable iff (rst_i)
		load_i && kind_i == PPSL_MSG_INTX |=> hdr1_o[1:0] == $past(line_i))
		else $error("interrupt line code wrong");
endmodule

// ### design/ppsl_bridge.sv
// Contract
// - type 1 config beyond secondary bus goes out as PCI type 1 cycle
// - type 1 address: bus 23:16, device 15:11, function 10:8, register 7:2, 01
// - type 0 cycles turn device number into one upper address select line, none for device 1xxxx
// - device 01111 selects address bit 31
// - sideband interrupt edges become assert and deassert messages upstream
// - low two code bits name the line: A 00, B 01, C 10, D 11
// - falling power event input sends a power event message upstream
// - power event requester is secondary bus, device 0, function 0
// - power event message tag is zero
// - power event message resent periodically while input stays low
// - lock output driven only when general control bit 12 is set
// - locked sequences only for downstream traffic
// - locked read handled as memory read, returns locked completion
// - locked read while unlocked requests the bus with REQ; the code requests only when general control bit 12 is set
// - grant with lock high: drive lock low after first address phase
// - owner holds lock asserted except during locked address phases
// - grant with lock low: drop REQ, wait lock high and idle bus
// - owned lock: run the locked read as memory read cycle
// - data returned: locked, block unrelated transactions
// - writes while locked go out as locked memory writes
// - leave lock only after unlock and earlier locked work completed
// - normal read during lock answered with unsupported request
`timescale 1ns/10ps
`include "ppsl_defs.svh"
module ppsl_bridge
	import ppsl_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [31:0] gen_ctrl_i,
	input  wire logic [7:0]  sec_bus_i,
	// configuration request from the link
	input  wire logic        cfg_req_i,
	input  wire logic [7:0]  cfg_bus_i,
	input  wire logic [4:0]  cfg_dev_i,
	input  wire logic [2:0]  cfg_func_i,
	input  wire logic [5:0]  cfg_reg_i,
	output logic             cfg_start_o,
	output logic             cfg_type1_o,
	output logic      [31:0] cfg_addr_o,
	// sideband interrupts and power event
	input  wire logic [3:0]  intx_n_i,
	input  wire logic        pme_n_i,
	output logic             msg_valid_o,
	input  wire logic        msg_ready_i,
	output logic      [31:0] msg_hdr0_o,
	output logic      [31:0] msg_hdr1_o,
	// downstream requests from the link
	input  wire logic        lk_rd_i,
	input  wire logic        mem_rd_i,
	input  wire logic        mem_wr_i,
	input  wire logic        unlock_i,
	input  wire logic        up_req_i,
	output logic             rd_locked_cpl_o,
	output logic             rd_ur_o,
	output logic             up_block_o,
	output logic             locked_o,
	// PCI bus side
	output logic             req_n_o,
	input  wire logic        gnt_n_i,
	input  wire logic        lock_n_i,
	output logic             lock_n_o,
	output logic             lock_oe_o,
	input  wire logic        bus_idle_i,
	output logic             pci_start_o,
	output logic             pci_write_o,
	output logic             pci_lock_o,
	input  wire logic        addr_phase_i,
	input  wire logic        pci_done_i
);
	localparam int RESEND = `PPSL_PME_RESEND_CYC;

	// configuration translation
	wire logic cfg_type1;
	assign cfg_type1 = cfg_bus_i != sec_bus_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_start_o <= 1'b0;
			cfg_type1_o <= 1'b0;
		end else begin
			cfg_start_o <= cfg_req_i;
			if (cfg_req_i) cfg_type1_o <= cfg_type1;
		end
	end
	ppsl_cfg_addr u_cfg (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.load_i  (cfg_req_i),
		.type1_i (cfg_type1),
		.bus_i   (cfg_bus_i),
		.dev_i   (cfg_dev_i),
		.func_i  (cfg_func_i),
		.reg_i   (cfg_reg_i),
		.addr_o  (cfg_addr_o)
	);

	// interrupt and power event tracking
	logic [3:0]  intx_sent;
	logic        pme_prev;
	logic        pme_due;
	logic [31:0] pme_cnt;
	logic        busy;
	wire logic [3:0] intx_diff;
	wire logic [1:0] intx_line;
	wire logic       intx_pend;
	wire logic       pme_fall;
	wire logic       take_pme;
	wire logic       take_intx;
	wire logic       idle;
	assign intx_diff = ~intx_n_i ^ intx_sent;
	assign intx_pend = |intx_diff;
	assign intx_line = intx_diff[0] ? 2'd0 : intx_diff[1] ? 2'd1 : intx_diff[2] ? 2'd2 : 2'd3;
	assign pme_fall  = pme_prev && !pme_n_i;
	assign idle      = !busy;
	assign take_pme  = idle && pme_due;
	assign take_intx = idle && !pme_due && intx_pend;

	// message header
	ppsl_msg_gen u_msg (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (take_pme || take_intx),
		.kind_i     (take_pme ? PPSL_MSG_PME : PPSL_MSG_INTX),
		.deassert_i (intx_sent[intx_line]),
		.line_i     (intx_line),
		.sec_bus_i  (sec_bus_i),
		.hdr0_o     (msg_hdr0_o),
		.hdr1_o     (msg_hdr1_o)
	);
	assign msg_valid_o = busy;

	// message scheduling and resend timer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			intx_sent <= 4'h0;
			pme_prev  <= 1'b1;
			pme_due   <= 1'b0;
			pme_cnt   <= 32'h0;
			busy      <= 1'b0;
		end else begin
			pme_prev <= pme_n_i;
			if (busy && msg_ready_i) busy <= 1'b0;
			if (take_intx) intx_sent[intx_line] <= ~intx_sent[intx_line];
			if (take_pme || take_intx) busy <= 1'b1;
			if (pme_n_i) begin
				pme_cnt <= 32'h0;
			end else if (pme_cnt == 32'(RESEND - 1)) begin
				pme_cnt <= 32'h0;
			end else begin
				pme_cnt <= pme_cnt + 32'h1;
			end
			if (pme_fall || (!pme_n_i && pme_cnt == 32'(RESEND - 1))) begin
				pme_due <= 1'b1;
			end else if (take_pme || pme_n_i) begin
				pme_due <= 1'b0;
			end
		end
	end

	// lock sequencer
	ppsl_lock_state_t state;
	ppsl_lock_state_t next_state;
	logic             own;
	logic             lock_drive;
	logic             wr_pend;
	wire logic        lock_en;
	wire logic        granted;
	assign lock_en = gen_ctrl_i[`PPSL_GCTL_LOCK_BIT];
	assign granted = !gnt_n_i;

	always_comb begin
		next_state = state;
		case (state)
			PPSL_LK_IDLE:    if (lk_rd_i && lock_en) next_state = PPSL_LK_REQ;
			PPSL_LK_REQ:     if (granted && bus_idle_i)
				next_state = lock_n_i ? PPSL_LK_READ : PPSL_LK_BACKOFF;
			PPSL_LK_BACKOFF: if (lock_n_i && bus_idle_i) next_state = PPSL_LK_REQ;
			PPSL_LK_READ:    if (pci_done_i) next_state = PPSL_LK_LOCKED;
			PPSL_LK_LOCKED: begin
				if (unlock_i) next_state = PPSL_LK_DRAIN;
				else if (mem_wr_i || lk_rd_i) next_state = PPSL_LK_WRITE;
			end
			PPSL_LK_WRITE:   if (pci_done_i) next_state = wr_pend ? PPSL_LK_DRAIN : PPSL_LK_LOCKED;
			PPSL_LK_DRAIN:   next_state = PPSL_LK_IDLE;
			default:         next_state = PPSL_LK_IDLE;
		endcase
	end

	// state, ownership and lock pin drive
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state      <= PPSL_LK_IDLE;
			own        <= 1'b0;
			lock_drive <= 1'b0;
			wr_pend    <= 1'b0;
		end else begin
			state <= next_state;
			if (state == PPSL_LK_LOCKED) wr_pend <= 1'b0;
			if (state == PPSL_LK_WRITE && unlock_i) wr_pend <= 1'b1;
			if (state == PPSL_LK_READ && !addr_phase_i) own <= 1'b1;
			if (next_state == PPSL_LK_IDLE) own <= 1'b0;
			lock_drive <= (own || (state == PPSL_LK_READ && !addr_phase_i)) && next_state != PPSL_LK_IDLE;
		end
	end

	// pin and transaction outputs
	assign lock_oe_o  = lock_en && (own || state == PPSL_LK_READ);
	assign lock_n_o   = !(lock_drive && !addr_phase_i);
	assign req_n_o    = !(state == PPSL_LK_REQ);
	assign pci_lock_o = state == PPSL_LK_READ || state == PPSL_LK_WRITE;
	assign locked_o   = state == PPSL_LK_LOCKED || state == PPSL_LK_WRITE || state == PPSL_LK_DRAIN;
	assign up_block_o = up_req_i && state != PPSL_LK_IDLE;

	// per-transfer pulses and completions
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pci_start_o     <= 1'b0;
			pci_write_o     <= 1'b0;
			rd_locked_cpl_o <= 1'b0;
			rd_ur_o         <= 1'b0;
		end else begin
			pci_start_o     <= (state == PPSL_LK_REQ && next_state == PPSL_LK_READ) ||
				(state == PPSL_LK_LOCKED && next_state == PPSL_LK_WRITE);
			pci_write_o     <= state == PPSL_LK_LOCKED && mem_wr_i;
			rd_locked_cpl_o <= state == PPSL_LK_READ && pci_done_i;
			rd_ur_o         <= mem_rd_i && locked_o;
		end
	end

	sequence s_grant_free;
		state == PPSL_LK_REQ && granted && bus_idle_i && lock_n_i;
	endsequence
	sequence s_grant_busy;
		state == PPSL_LK_REQ && granted && bus_idle_i && !lock_n_i;
	endsequence
	a_lock_enable: assert property (@(posedge clk_i) disable iff (rst_i)
		!lock_en |-> !lock_oe_o) else $error("lock pin driven while disabled");
	a_req_on_lkrd: assert property (@(posedge clk_i) disable iff (rst_i)
		state == PPSL_LK_IDLE && lk_rd_i && lock_en |=> !req_n_o) else $error("no request for locked read");
	a_backoff_req: assert property (@(posedge clk_i) disable iff (rst_i)
		s_grant_busy |=> req_n_o ##1 (req_n_o || $past(lock_n_i && bus_idle_i)))
		else $error("request not dropped on busy lock");
	a_grant_start: assert property (@(posedge clk_i) disable iff (rst_i)
		s_grant_free |=> pci_start_o && pci_lock_o) else $error("locked read not started");
	a_addr_release: assert property (@(posedge clk_i) disable iff (rst_i)
		addr_phase_i |-> lock_n_o) else $error("lock held during address phase");
	a_lock_held: assert property (@(posedge clk_i) disable iff (rst_i)
		own && lock_en && !addr_phase_i |-> !lock_n_o && lock_oe_o) else $error("owned lock not held low");
	a_ur_read: assert property (@(posedge clk_i) disable iff (rst_i)
		mem_rd_i && locked_o |=> rd_ur_o) else $error("normal read not refused");
	a_unlock_exit: assert property (@(posedge clk_i) disable iff (rst_i)
		state == PPSL_LK_LOCKED && unlock_i |=> ##1 state == PPSL_LK_IDLE) else $error("unlock not honoured");
	a_pme_first: assert property (@(posedge clk_i) disable iff (rst_i)
		pme_fall && idle && !intx_pend |=> ##1 msg_valid_o) else $error("power event not sent");
endmodule

// ### verif/ppsl_pci_model.sv
`timescale 1ns/10ps
// behavioural pci bus side: arbiter, one target and the pulled-up lock wire
module ppsl_pci_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       req_n_i,
	input  wire logic       pci_start_i,
	input  wire logic       lock_n_i,
	input  wire logic       lock_oe_i,
	input  wire logic       other_lock_i,
	input  wire logic [3:0] dly_i,
	output logic            gnt_n_o,
	output logic            lock_n_o,
	output logic            bus_idle_o,
	output logic            addr_phase_o,
	output logic            done_o
);
	logic [3:0] cnt;
	// wire level: pulled high unless another master or the bridge pulls it low
	assign lock_n_o   = ~(other_lock_i | (lock_oe_i & ~lock_n_i));
	assign bus_idle_o = (cnt == 4'h0) & ~addr_phase_o;
	// grant follows request, target answers after dly_i cycles
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gnt_n_o      <= 1'b1;
			addr_phase_o <= 1'b0;
			done_o       <= 1'b0;
			cnt          <= 4'h0;
		end else begin
			gnt_n_o      <= req_n_i;
			addr_phase_o <= pci_start_i;
			done_o       <= (cnt == 4'h1);
			cnt          <= pci_start_i ? dly_i : ((cnt != 4'h0) ? cnt - 4'h1 : 4'h0);
		end
	end
endmodule

// ### verif/ppsl_bridge_tb.sv
`timescale 1ns/10ps
`include "ppsl_defs.svh"
module ppsl_bridge_tb;
	import ppsl_pkg::*;
	typedef struct packed {logic [7:0] bus; logic [4:0] dev; logic [2:0] func; logic [5:0] rg; logic [7:0] sec;
		logic t1; logic [31:0] addr;} ppsl_row_t;
	logic clk_i, rst_i, cfg_req_i, pme_n_i, msg_ready_i, lk_rd_i, mem_rd_i, mem_wr_i, unlock_i, up_req_i;
	logic [31:0] gen_ctrl_i;
	logic [7:0] sec_bus_i, cfg_bus_i;
	logic [4:0] cfg_dev_i;
	logic [2:0] cfg_func_i;
	logic [5:0] cfg_reg_i;
	logic [3:0] intx_n_i, dly;
	logic cfg_start_o, cfg_type1_o, msg_valid_o, rd_locked_cpl_o, rd_ur_o, up_block_o, locked_o, req_n_o, lock_n_o;
	logic lock_oe_o, pci_start_o, pci_write_o, pci_lock_o, gnt_n, lock_w, bus_idle, addr_phase, done, other_lock;
	logic [31:0] cfg_addr_o, msg_hdr0_o, msg_hdr1_o;
	int fails = 0;
	int checked = 0;
	int at;
	// request fields, then expected type and address word
	ppsl_row_t rows [6] = '{
		'{8'h05, 5'h1a, 3'h5, 6'h2b, 8'h01, 1'b1, 32'h0005_d5ad},
		'{8'h01, 5'h00, 3'h2, 6'h11, 8'h01, 1'b0, 32'h0001_0244},
		'{8'h01, 5'h0f, 3'h7, 6'h3f, 8'h01, 1'b0, 32'h8000_07fc},
		'{8'h01, 5'h10, 3'h0, 6'h01, 8'h01, 1'b0, 32'h0000_0004},
		'{8'hff, 5'h1f, 3'h1, 6'h20, 8'hfe, 1'b1, 32'h00ff_f981},
		'{8'h3c, 5'h07, 3'h3, 6'h05, 8'h3c, 1'b0, 32'h0080_0314}};
	ppsl_bridge dut (.clk_i(clk_i), .rst_i(rst_i), .gen_ctrl_i(gen_ctrl_i), .sec_bus_i(sec_bus_i),
		.cfg_req_i(cfg_req_i), .cfg_bus_i(cfg_bus_i), .cfg_dev_i(cfg_dev_i), .cfg_func_i(cfg_func_i),
		.cfg_reg_i(cfg_reg_i), .cfg_start_o(cfg_start_o), .cfg_type1_o(cfg_type1_o), .cfg_addr_o(cfg_addr_o),
		.intx_n_i(intx_n_i), .pme_n_i(pme_n_i), .msg_valid_o(msg_valid_o), .msg_ready_i(msg_ready_i),
		.msg_hdr0_o(msg_hdr0_o), .msg_hdr1_o(msg_hdr1_o), .lk_rd_i(lk_rd_i), .mem_rd_i(mem_rd_i),
		.mem_wr_i(mem_wr_i), .unlock_i(unlock_i), .up_req_i(up_req_i), .rd_locked_cpl_o(rd_locked_cpl_o),
		.rd_ur_o(rd_ur_o), .up_block_o(up_block_o), .locked_o(locked_o), .req_n_o(req_n_o), .gnt_n_i(gnt_n),
		.lock_n_i(lock_w), .lock_n_o(lock_n_o), .lock_oe_o(lock_oe_o), .bus_idle_i(bus_idle),
		.pci_start_o(pci_start_o), .pci_write_o(pci_write_o), .pci_lock_o(pci_lock_o),
		.addr_phase_i(addr_phase), .pci_done_i(done));
	ppsl_pci_model pci (.clk_i(clk_i), .rst_i(rst_i), .req_n_i(req_n_o), .pci_start_i(pci_start_o),
		.lock_n_i(lock_n_o), .lock_oe_i(lock_oe_o), .other_lock_i(other_lock), .dly_i(dly), .gnt_n_o(gnt_n),
		.lock_n_o(lock_w), .bus_idle_o(bus_idle), .addr_phase_o(addr_phase), .done_o(done));
	// result comparisons
	task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic check1(input string name, input logic exp, input logic got);
		check32(name, {31'h0, exp}, {31'h0, got});
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// observed condition by index
	function automatic logic pick(input int k);
		case (k)
			0: return msg_valid_o;
			1: return ~req_n_o;
			2: return pci_start_o;
			3: return rd_locked_cpl_o;
			4: return rd_ur_o;
			5: return req_n_o;
			default: return ~locked_o;
		endcase
	endfunction
	// first negedge index below lim at which the condition holds, -1 if none
	task automatic watch(input int k, input int lim, output int first);
		first = -1;
		for (int i = 0; i < lim && first < 0; i++) begin
			if (pick(k) === 1'b1) first = i;
			else @(negedge clk_i);
		end
	endtask
	// one-cycle request pulse, ends on the next falling edge
	task automatic pulse(input int k);
		{lk_rd_i, mem_rd_i, mem_wr_i, unlock_i, cfg_req_i} = 5'h10 >> k;
		@(negedge clk_i);
		{lk_rd_i, mem_rd_i, mem_wr_i, unlock_i, cfg_req_i} = 5'h00;
	endtask
	// wait for a message, compare its headers, accept it
	task automatic take_msg(input int lim, input logic [7:0] h0, input logic [31:0] h1, input logic [31:0] mask);
		int n;
		watch(0, lim, n);
		check1("msg_seen", 1'b1, n >= 0);
		check32("msg_hdr0", {h0, 24'h0}, msg_hdr0_o & 32'hff000000);
		check32("msg_hdr1", h1, msg_hdr1_o & mask);
		msg_ready_i = 1'b1;
		@(negedge clk_i);
		msg_ready_i = 1'b0;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		#(8 * 60000);
		fails++;
		conclude();
	end
	initial begin
		{rst_i, cfg_req_i, lk_rd_i, mem_rd_i, mem_wr_i, unlock_i, up_req_i, msg_ready_i, other_lock} = 9'h100;
		{gen_ctrl_i, sec_bus_i, cfg_bus_i, cfg_dev_i, cfg_func_i, cfg_reg_i} = '0;
		{intx_n_i, pme_n_i, dly} = 9'h1f1;
		repeat (20) @(negedge clk_i);
		check1("req_n_o", 1'b1, req_n_o);
		check1("lock_oe_o", 1'b0, lock_oe_o);
		check1("msg_valid_o", 1'b0, msg_valid_o);
		rst_i = 1'b0;
		@(negedge clk_i);
		// configuration translation table
		foreach (rows[i]) begin
			{cfg_bus_i, cfg_dev_i, cfg_func_i, cfg_reg_i, sec_bus_i} = {rows[i].bus, rows[i].dev, rows[i].func,
				rows[i].rg, rows[i].sec};
			pulse(4);
			check1("cfg_start_o", 1'b1, cfg_start_o);
			check1("cfg_type1_o", rows[i].t1, cfg_type1_o);
			if (rows[i].t1)
				check32("cfg_addr_t1", rows[i].addr, cfg_addr_o);
			else
				check32("cfg_addr_t0", rows[i].addr, cfg_addr_o);
			@(negedge clk_i);
		end
		// sideband interrupt lines, assert then release each
		for (int k = 0; k < 4; k++) begin
			intx_n_i[k] = 1'b0;
			take_msg(50, `PPSL_HDR0_INTX, `PPSL_MSG_ASSERT_INTX | k[7:0], 32'hff);
			intx_n_i[k] = 1'b1;
			take_msg(50, `PPSL_HDR0_INTX, `PPSL_MSG_DEASSERT_INTX | k[7:0], 32'hff);
		end
		// power event: first message, periodic resend, silence after release
		pme_n_i = 1'b0;
		take_msg(50, `PPSL_HDR0_PME, {sec_bus_i, 8'h00, `PPSL_PME_TAG, `PPSL_MSG_PM_PME}, 32'hffffffff);
		watch(0, `PPSL_PME_RESEND_CYC - 100, at);
		check1("pme_early", 1'b1, at < 0);
		take_msg(300, `PPSL_HDR0_PME, {sec_bus_i, 8'h00, `PPSL_PME_TAG, `PPSL_MSG_PM_PME}, 32'hffffffff);
		pme_n_i = 1'b1;
		watch(0, `PPSL_PME_RESEND_CYC + 500, at);
		check1("pme_stopped", 1'b1, at < 0);
		// lock disabled: no request
		pulse(0);
		watch(1, 20, at);
		check1("req_disabled", 1'b1, at < 0);
		// enabled but lock held elsewhere: request, then back off
		gen_ctrl_i[`PPSL_GCTL_LOCK_BIT] = 1'b1;
		other_lock = 1'b1;
		pulse(0);
		check1("req_n_o", 1'b0, req_n_o);
		watch(5, 10, at);
		check1("req_backoff", 1'b1, at >= 0);
		watch(1, 20, at);
		check1("req_wait", 1'b1, at < 0);
		other_lock = 1'b0;
		watch(2, 40, at);
		check1("rd_start", 1'b1, at >= 0);
		check1("pci_write_o", 1'b0, pci_write_o);
		watch(3, 40, at);
		check1("rd_cpl", 1'b1, at >= 0);
		check1("lock_wire", 1'b0, lock_w);
		check1("locked_o", 1'b1, locked_o);
		up_req_i = 1'b1;
		#1 check1("up_block_o", 1'b1, up_block_o);
		@(negedge clk_i);
		up_req_i = 1'b0;
		pulse(1);
		watch(4, 5, at);
		check1("rd_ur", 1'b1, at >= 0);
		// slow locked write, unlock while it is still pending
		dly = 4'h6;
		pulse(2);
		watch(2, 20, at);
		check1("wr_start", 1'b1, at >= 0);
		check1("pci_write_o", 1'b1, pci_write_o);
		check1("pci_lock_o", 1'b1, pci_lock_o);
		@(negedge clk_i);
		check1("lock_addr", 1'b1, lock_w);
		pulse(3);
		check1("lock_hold", 1'b0, lock_w);
		watch(6, 5, at);
		check1("unlock_early", 1'b1, at < 0);
		watch(6, 30, at);
		check1("unlocked", 1'b1, at >= 0);
		repeat (3) @(negedge clk_i);
		check1("lock_release", 1'b1, lock_w);
		// second sequence on a free lock, unlock with nothing pending
		dly = 4'h1;
		pulse(0);
		watch(3, 40, at);
		check1("rd_cpl2", 1'b1, at >= 0);
		pulse(3);
		check1("locked_drain", 1'b1, locked_o);
		@(negedge clk_i);
		check1("locked_exit", 1'b0, locked_o);
		up_req_i = 1'b1;
		#1 check1("up_block_idle", 1'b0, up_block_o);
		@(negedge clk_i);
		up_req_i = 1'b0;
		conclude();
	end
endmodule
